// ==== nv_cell_array_model.sv ====
`timescale 1ns/1ps
module nv_cell_array_model
  import nv_port_pkg::*;
#(
  // kept off a whole number of clock periods so the line never rises on a sampling edge
  parameter int STORE_NS = 1010
)
(
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              select_n_in,
  input  wire logic              write_n_in,
  input  wire logic              drive_n_in,
  input  wire logic [DATA_W-1:0] dq_in,
  input  wire logic              store_busy_n_in,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   dq_oe_n_out,
  output logic                   hold_low_out
);
  logic [DATA_W-1:0] cells  [2**ADDR_W];
  logic [DATA_W-1:0] shadow [2**ADDR_W];
  logic              dirty;
  int                store_count;        // endurance limit lies far beyond any run
  wire rd_on = !select_n_in && !drive_n_in && write_n_in && store_busy_n_in;
  wire wr_on = !select_n_in && !write_n_in && store_busy_n_in;
  wire #(READ_ACCESS_NS) rd_late = rd_on;
  ////////////////////////////////////////////////////////////////////////
  // released or not yet valid lines show the inverse so stale data never passes
  assign dq_oe_n_out = !rd_on;
  assign dq_out      = (rd_on && rd_late) ? cells[addr_in] : ~cells[addr_in];
  initial begin
    dirty        = 1'b0;
    store_count  = 0;
    hold_low_out = 1'b0;
  end
  // data is taken at the edge that ends the write
  always @(negedge wr_on) begin
    // the first fall out of the unknown start-up level carries no data and must not mark the array dirty
    if ((^addr_in !== 1'bx) && (^dq_in !== 1'bx)) begin
      cells[addr_in] = dq_in;
      dirty          = 1'b1;
    end
  end
  always @(negedge store_busy_n_in) begin
    if (dirty) begin
      hold_low_out = 1'b1;
      #(STORE_NS);
      shadow       = cells;
      store_count++;
      dirty        = 1'b0;
      hold_low_out = 1'b0;
    end
  end
endmodule : nv_cell_array_model

// ==== nv_pin_drv.sv ====
`timescale 1ns/1ps
module nv_pin_drv
  import nv_port_pkg::*;
(
  nv_pins_if.pins    p,
  input  wire logic  store_busy_n_in,
  output logic       select_n_out,
  output logic       write_n_out,
  output logic       drive_n_out,
  output logic [7:0] dq_out,
  output logic       dq_oe_n_out
);
  // pin stage: passes the registered strobes out and reports a low store_busy_n line
  assign select_n_out = p.select_n;
  assign write_n_out  = p.write_n;
  assign drive_n_out  = p.drive_n;
  assign dq_out       = p.dq_o;
  assign dq_oe_n_out  = p.bus_oe_n;
  assign p.busy_seen  = ~store_busy_n_in;
endmodule : nv_pin_drv

// ==== nv_pins_if.sv ====
`timescale 1ns/1ps
interface nv_pins_if;
  import nv_port_pkg::*;
  logic              select_n;
  logic              write_n;
  logic              drive_n;
  logic              bus_oe_n;
  logic [DATA_W-1:0] dq_o;
  logic              busy_seen;
  modport ctrl (output select_n, output write_n, output drive_n, output bus_oe_n, output dq_o,
                input busy_seen);
  modport pins (input select_n, input write_n, input drive_n, input bus_oe_n, input dq_o,
                output busy_seen);
endinterface : nv_pins_if

// ==== nv_port_pkg.sv ====
package nv_port_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 50;
  // worst-case access and setup figures of the slowest speed grade, in ns
  localparam int ADDRESS_ACCESS_DELAY_NS       = 45;
  localparam int SELECT_ACCESS_DELAY_NS        = 45;
  localparam int OUTPUT_DRIVE_ACCESS_DELAY_NS  = 25;
  localparam int WRITE_DATA_SETUP_NS           = 30;
  localparam int WRITE_PULSE_NS                = 45;
  localparam int BUS_TURN_NS                   = 15;
  // least times round up to whole cycles, never below one
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cycles
  localparam int READ_ACCESS_NS = (SELECT_ACCESS_DELAY_NS > OUTPUT_DRIVE_ACCESS_DELAY_NS) ?
                                  SELECT_ACCESS_DELAY_NS : OUTPUT_DRIVE_ACCESS_DELAY_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] READ_CYCLES  = CNT_W'(ns_to_cycles(READ_ACCESS_NS));
  localparam logic [CNT_W-1:0] WRITE_CYCLES = CNT_W'(ns_to_cycles(
    (WRITE_PULSE_NS > WRITE_DATA_SETUP_NS) ? WRITE_PULSE_NS : WRITE_DATA_SETUP_NS));
  localparam logic [CNT_W-1:0] TURN_CYCLES  = CNT_W'(ns_to_cycles(BUS_TURN_NS));
  localparam logic [CNT_W-1:0] CNT_ZERO     = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST    = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RST    = 8'h00;
  typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WR, ST_TURN, ST_STORE_REQ, ST_BUSY} port_state_t;
endpackage : nv_port_pkg

// ==== nv_static_ram_port.sv ====
`timescale 1ns/1ps
// Function
// R1 - memory is 8192 bytes on 13 address lines with 8 two-way data lines
// R2 - device selected only while select is low
// R3 - device drives data only while output drive is low in a read
// R4 - read happens with select and drive low, write strobe and busy high
// R5 - read data follows address and holds until a control change
// R6 - read data valid after later of select and drive access delays
// R7 - write happens with select and strobe low while busy high
// R8 - host holds address stable through the whole write access
// R9 - host presents write data a setup time before the ending edge
// R10 - host keeps output drive high throughout a write
// R11 - device turns its buffers off shortly after write strobe falls
// R12 - device pulls busy low while a store runs
// R13 - any party may pull busy low to request a store
// R14 - busy line floats high through a weak pull-up
// R15 - device blocks reads and writes during store or recall
// R16 - at most one million stores, unlimited other accesses
// R17 - store request acts only after a write since last store or recall
// R18 - writes requested after busy falls wait until it returns high
// R19 - device keeps a full shadow array copied on store and recall; the model copies shadow on store only and has no recall
module nv_static_ram_port
  import nv_port_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              rst_b_in,
  input  wire logic              req_valid_in,
  input  wire logic              req_write_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic [DATA_W-1:0] req_wdata_in,
  input  wire logic              store_req_in,
  output logic                   req_ready_out,
  output logic                   rsp_valid_out,
  output logic [DATA_W-1:0]      rsp_rdata_out,
  output logic                   busy_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   select_n_out,
  output logic                   write_n_out,
  output logic                   drive_n_out,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   dq_oe_n_out,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic                   store_busy_n_out,
  output logic                   store_busy_oe_n_out,
  input  wire logic              store_busy_n_in
);

  nv_pins_if pins ();

  port_state_t             state_q;
  port_state_t             state_d;
  logic [CNT_W-1:0]        cnt_q;
  logic [ADDR_W-1:0]       addr_q;
  logic [DATA_W-1:0]       wdata_q;
  logic [DATA_W-1:0]       rdata_q;
  logic                    rsp_q;
  logic                    select_n_q;
  logic                    write_n_q;
  logic                    drive_n_q;
  logic                    bus_oe_n_q;
  logic                    pull_q;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire busy_low   = pins.busy_seen;
  wire cnt_done   = (cnt_q == CNT_ZERO);
  wire idle       = (state_q == ST_IDLE);
  wire take_req   = idle & req_valid_in & ~busy_low;        // [R15] [R18]
  wire take_store = idle & ~req_valid_in & store_req_in & ~busy_low;
  wire [CNT_W-1:0] cnt_load =
    (take_req & req_write_in) ? WRITE_CYCLES :
    take_req                  ? READ_CYCLES  :
    (state_q == ST_WR) & cnt_done ? TURN_CYCLES : CNT_ZERO;
  wire cnt_loading = take_req | ((state_q == ST_WR) & cnt_done);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take_req) begin
          state_d = req_write_in ? ST_WR : ST_RD;
        end else if (take_store) begin
          state_d = ST_STORE_REQ;
        end else if (busy_low) begin
          state_d = ST_BUSY;
        end
      end
      ST_RD: begin
        if (cnt_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_WR: begin
        if (cnt_done) begin
          state_d = ST_TURN;
        end
      end
      ST_TURN: begin
        if (cnt_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_STORE_REQ: begin
        if (busy_low) begin
          state_d = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (~busy_low) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= ST_IDLE;
      cnt_q   <= CNT_ZERO;
    end else begin
      state_q <= state_d;
      if (cnt_loading) begin
        cnt_q <= cnt_load;
      end else if (!cnt_done) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end

  // address and data held for the whole access; the latch only loads in idle
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_q  <= ADDR_RST;
      wdata_q <= DATA_RST;
    end else if (take_req) begin
      addr_q  <= req_addr_in;                            // [R8] [R1]
      wdata_q <= req_wdata_in;                           // [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin strobes

  wire next_rd   = (state_d == ST_RD);
  wire next_wr   = (state_d == ST_WR);
  wire next_turn = (state_d == ST_TURN);

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      select_n_q <= 1'b1;
      write_n_q  <= 1'b1;
      drive_n_q  <= 1'b1;
      bus_oe_n_q <= 1'b1;
      pull_q     <= 1'b0;
    end else begin
      select_n_q <= ~(next_rd | next_wr);                  // [R2] [R4] [R7]
      write_n_q  <= ~next_wr;                              // [R7]
      drive_n_q  <= ~next_rd;                              // [R10] [R3]
      // data held through both turn cycles so it outlasts the strobe rise
      bus_oe_n_q <= ~(next_wr | next_turn);                // [R9]
      pull_q     <= (state_d == ST_STORE_REQ);             // [R13]
    end
  end

  // sample on the last counted cycle, once the later access delay has passed
  wire rd_sample = (state_q == ST_RD) & cnt_done;        // [R6] [R5]

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= DATA_RST;
      rsp_q   <= 1'b0;
    end else begin
      rsp_q <= rd_sample | ((state_q == ST_TURN) & cnt_done);
      if (rd_sample) begin
        rdata_q <= dq_in;
      end
    end
  end

  assign pins.select_n = select_n_q;
  assign pins.write_n  = write_n_q;
  assign pins.drive_n  = drive_n_q;
  assign pins.bus_oe_n = bus_oe_n_q;
  assign pins.dq_o     = wdata_q;

  nv_pin_drv u_pin_drv (
    .p               (pins.pins),
    .store_busy_n_in (store_busy_n_in),
    .select_n_out    (select_n_out),
    .write_n_out     (write_n_out),
    .drive_n_out     (drive_n_out),
    .dq_out          (dq_out),
    .dq_oe_n_out     (dq_oe_n_out)
  );

  // open drain: only ever drives low, the pull-up restores high
  assign store_busy_n_out    = 1'b0;                     // [R14]
  assign store_busy_oe_n_out = ~pull_q;                  // [R13]
  assign addr_out            = addr_q;
  assign req_ready_out       = idle & ~busy_low;          // [R12] [R18]
  assign rsp_valid_out       = rsp_q;
  assign rsp_rdata_out       = rdata_q;
  assign busy_out            = busy_low;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence write_pulse_s;
    !write_n_q && !select_n_q && drive_n_q;
  endsequence

  sequence read_pulse_s;
    !select_n_q && !drive_n_q && write_n_q;
  endsequence

  no_drive_in_write_a: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [R10]
    !write_n_q |-> drive_n_q) else $error("output drive low during write");

  addr_hold_write_a: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [R8]
    (!write_n_q && $past(!write_n_q)) |-> $stable(addr_q)) else $error("address moved in write");

  data_setup_a: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [R9]
    ($rose(write_n_q)) |-> (!bus_oe_n_q && $past(!bus_oe_n_q))) else $error("write data not set up");

  write_len_a: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [R7]
    $fell(write_n_q) |-> write_pulse_s [*2]) else $error("write strobe too short");

  read_len_a: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [R6]
    $fell(drive_n_q) |-> read_pulse_s ##1 read_pulse_s) else $error("read ended before access time");

  select_idle_a: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [R2]
    (state_q == ST_IDLE) |-> select_n_q) else $error("selected while idle");

  no_access_busy_a: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [R15]
    (busy_low && idle) |=> select_n_q) else $error("access started while busy");

  store_pull_a: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [R13]
    take_store |=> !store_busy_oe_n_out) else $error("store request not driven");

  read_rsp_a: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [R4]
    (take_req && !req_write_in) |-> ##[3:4] rsp_valid_out) else $error("read answer missing");

endmodule : nv_static_ram_port

// ==== testbench.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module testbench;
  import nv_port_pkg::*;
  logic              clock_in     = 1'b0;
  logic              rst_b_in     = 1'b0;
  logic              req_valid_in = 1'b0;
  logic              req_write_in = 1'b0;
  logic              store_req_in = 1'b0;
  logic              ext_pull     = 1'b0;
  logic [ADDR_W-1:0] req_addr_in  = '0;
  logic [DATA_W-1:0] req_wdata_in = '0;
  logic              req_ready, rsp_valid, busy, sel_n, wr_n, drv_n, dq_oe_n, sb_n, sb_oe_n, m_oe_n, hold;
  logic [DATA_W-1:0] rdata, dq_host, m_dq;
  logic [ADDR_W-1:0] addr;
  int                fails    = 0;
  int                compares = 0;
  wire [DATA_W-1:0]  dq_line  = !dq_oe_n ? dq_host : m_dq;
  wire               sb_line  = ((!sb_oe_n && !sb_n) || hold || ext_pull) ? 1'b0 : 1'b1;
  always #25 clock_in = ~clock_in;
  nv_static_ram_port DUT (.clock_in(clock_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid_in),
    .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .store_req_in(store_req_in), .req_ready_out(req_ready), .rsp_valid_out(rsp_valid),
    .rsp_rdata_out(rdata), .busy_out(busy), .addr_out(addr), .select_n_out(sel_n),
    .write_n_out(wr_n), .drive_n_out(drv_n), .dq_out(dq_host), .dq_oe_n_out(dq_oe_n),
    .dq_in(dq_line), .store_busy_n_out(sb_n), .store_busy_oe_n_out(sb_oe_n), .store_busy_n_in(sb_line));
  nv_cell_array_model mdl (.addr_in(addr), .select_n_in(sel_n), .write_n_in(wr_n), .drive_n_in(drv_n),
    .dq_in(dq_line), .store_busy_n_in(sb_line), .dq_out(m_dq), .dq_oe_n_out(m_oe_n), .hold_low_out(hold));
  ////////////////////////////////////////////////////////////////////////
  task results;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  // request held until the rising edge after ready is seen high on a falling edge
  task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic r;
    int   n;
    req_valid_in = 1'b1;
    req_write_in = w;
    req_addr_in  = a;
    req_wdata_in = d;
    n = 0;
    do begin
      @(negedge clock_in) r = req_ready;
      @(posedge clock_in) n++;
    end while (!r && n < 60);
    #1 req_valid_in = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      if (wr_n === 1'b0) `CHK(drv_n, 1'b1)
      if (wr_n === 1'b0) `CHK(sb_line, 1'b1)
      if (dq_oe_n === 1'b0) `CHK(m_oe_n, 1'b1)
      if (sel_n === 1'b0) `CHK(addr, a)
      @(posedge clock_in) #1 n++;
    end
    `CHK(rsp_valid, 1'b1)
  endtask : access
  task scn_idle;
    `CHK({sel_n, wr_n, drv_n, dq_oe_n, sb_oe_n, sb_line}, 6'h3f)
    `CHK(sb_n, 1'b0)
  endtask : scn_idle
  task scn_boundaries;
    logic [ADDR_W-1:0] a [4] = '{13'h0000, 13'h0001, 13'h1555, 13'h1fff};
    for (int i = 0; i < 4; i++) access(1'b1, a[i], 8'h3c ^ a[i][7:0]);
    for (int i = 0; i < 4; i++) begin
      access(1'b0, a[i], 8'h00);
      `CHK(rdata, 8'h3c ^ a[i][7:0])
    end
  endtask : scn_boundaries
  task scn_store_blocks;
    int n;
    access(1'b1, 13'h0007, 8'h5a);
    store_req_in = 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(posedge clock_in) #1 n++;
    end
    store_req_in = 1'b0;
    `CHK(req_ready, 1'b0)
    access(1'b1, 13'h0007, 8'ha5);
    `CHK(mdl.shadow[7], 8'h5a)
    access(1'b0, 13'h0007, 8'h00);
    `CHK(rdata, 8'ha5)
  endtask : scn_store_blocks
  task scn_store_needs_write;
    int n;
    for (int k = 0; k < 2; k++) begin
      store_req_in = 1'b1;
      @(posedge clock_in) #1 store_req_in = 1'b0;
      n = 0;
      while ((busy !== 1'b0 || req_ready !== 1'b1) && n < 100) begin
        @(posedge clock_in) #1 n++;
      end
      `CHK(mdl.store_count, 2)
    end
  endtask : scn_store_needs_write
  // an outside party holds the line low: a pending read must wait until it is let go
  task scn_ext_busy;
    req_valid_in = 1'b1;
    req_write_in = 1'b0;
    req_addr_in  = 13'h0001;
    ext_pull     = 1'b1;
    repeat (3) begin
      @(posedge clock_in) #1;
      `CHK({busy, req_ready, sel_n}, 3'h5)
    end
    ext_pull = 1'b0;
    access(1'b0, 13'h0001, 8'h00);
    `CHK(rdata, 8'h3d)
  endtask : scn_ext_busy
  initial begin
    repeat (2) @(posedge clock_in);
    #1 rst_b_in = 1'b1;
    scn_idle();
    scn_boundaries();
    scn_store_blocks();
    scn_store_needs_write();
    scn_ext_busy();
    results();
  end
  initial begin
    #100000;
    fails++;
    results();
  end
endmodule : testbench
